// ---- core/fanout_cfg_pkg.sv ----
// constants and types shared by the configuration register bank and its serial engine
package fanout_cfg_pkg;
    // register indexes
    localparam logic [7:0] IDX_GATE_SWING   = 8'h01;
    localparam logic [7:0] IDX_EDGE_LO      = 8'h02;
    localparam logic [7:0] IDX_EDGE_HI      = 8'h03;
    localparam logic [7:0] IDX_RSVD         = 8'h04;
    localparam logic [7:0] IDX_REV          = 8'h05;
    localparam logic [7:0] IDX_PART         = 8'h06;
    localparam logic [7:0] IDX_LEN          = 8'h07;
    // field positions
    localparam int         GATE4_BIT        = 5;
    localparam int         SWING_LSB        = 0;
    localparam int         EDGE0_BIT        = 1;
    localparam int         EDGE1_BIT        = 3;
    localparam int         EDGE2_BIT        = 5;
    localparam int         EDGE3_BIT        = 6;
    localparam int         EDGE4_BIT        = 0;
    localparam int         LEN_W            = 5;
    // fixed read values of reserved bits
    localparam logic [7:0] GATE_SWING_FIXED = 8'h4c;
    localparam logic [7:0] EDGE_LO_FIXED    = 8'h95;
    localparam logic [7:0] EDGE_HI_FIXED    = 8'h46;
    localparam logic [7:0] RSVD_VALUE       = 8'hff;
    localparam logic [7:0] LEN_FIXED        = 8'h00;
    localparam logic [7:0] UNMAPPED_VALUE   = 8'h00;
    // reset values
    localparam logic       GATE4_RST        = 1'b1;
    localparam logic [1:0] SWING_RST        = 2'h2;
    localparam logic [4:0] EDGE_RST         = 5'h1f;
    localparam logic [4:0] LEN_RST          = 5'h08;
    // serial framing
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
    localparam logic [1:0] STRAP_SETTLE     = 2'h2;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b000,
        BUS_ADDR  = 3'b001,
        BUS_ACK   = 3'b011,
        BUS_RX    = 3'b010,
        BUS_TX    = 3'b110,
        BUS_TXACK = 3'b111
    } bus_state_e;

    typedef enum logic [1:0] {
        WR_INDEX = 2'b00,
        WR_COUNT = 2'b01,
        WR_DATA  = 2'b11
    } wr_phase_e;
endpackage

// ---- core/smbus_byte_if.sv ----
// byte-level carrier between the serial engine and the register bank
`timescale 1ns/10ps
interface smbus_byte_if;
    logic [6:0] slaveAddr;
    logic       frameStart;
    logic       frameStop;
    logic       rxValid;
    logic [7:0] rxData;
    logic       txTake;
    logic [7:0] txData;

    modport engine (input slaveAddr, input txData, output frameStart, output frameStop,
                    output rxValid, output rxData, output txTake);
    modport regs (output slaveAddr, output txData, input frameStart, input frameStop,
                  input rxValid, input rxData, input txTake);
endinterface

// ---- core/smbus_byte_engine.sv ----
// serial bit engine: start/stop detection, address match, byte shift and acknowledge
`timescale 1ns/10ps
module smbus_byte_engine
    import fanout_cfg_pkg::*;
(
    input  wire logic         clk,     // system clock
    input  wire logic         rst_n,   // synchronous reset
    input  wire logic         sclIn,   // serial clock pin
    input  wire logic         sdaIn,   // serial data pin level
    output logic              sdaOut,  // serial data drive value
    output logic              sdaOe_n, // serial data enable, low drives
    smbus_byte_if.engine      bus      // byte side
);
    typedef struct packed {
        bus_state_e st;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic       isAddr;
        logic       rw;
        logic       hostAck;
        logic       drive;
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic       sclPrev;
        logic       sdaPrev;
        logic       rxValid;
        logic       frameStart;
        logic       frameStop;
        logic       txTake;
    } eng_s;

    localparam eng_s ENG_RST = '{st: BUS_IDLE, bitCnt: 4'h0, shift: 8'h00, isAddr: 1'b0, rw: 1'b0,
                                 hostAck: 1'b0, drive: 1'b0, sclSync: 2'h3, sdaSync: 2'h3,
                                 sclPrev: 1'b1, sdaPrev: 1'b1, rxValid: 1'b0, frameStart: 1'b0,
                                 frameStop: 1'b0, txTake: 1'b0};

    eng_s r_reg;
    eng_s r_next;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic startCond;
    logic stopCond;

    assign scl       = r_reg.sclSync[1];
    assign sda       = r_reg.sdaSync[1];
    assign rise      = scl & ~r_reg.sclPrev;
    assign fall      = ~scl & r_reg.sclPrev;
    assign startCond = scl & r_reg.sclPrev & r_reg.sdaPrev & ~sda;
    assign stopCond  = scl & r_reg.sclPrev & ~r_reg.sdaPrev & sda;

    always_comb begin
        r_next            = r_reg;
        r_next.sclSync    = {r_reg.sclSync[0], sclIn};
        r_next.sdaSync    = {r_reg.sdaSync[0], sdaIn};
        r_next.sclPrev    = scl;
        r_next.sdaPrev    = sda;
        r_next.rxValid    = 1'b0;
        r_next.frameStart = 1'b0;
        r_next.frameStop  = 1'b0;
        r_next.txTake     = 1'b0;
        if (startCond) begin
            r_next.st         = BUS_ADDR;
            r_next.bitCnt     = 4'h0;
            r_next.drive      = 1'b0;
            r_next.frameStart = 1'b1;
        end else if (stopCond) begin
            r_next.st        = BUS_IDLE;
            r_next.drive     = 1'b0;
            r_next.frameStop = 1'b1;
        end else begin
            unique case (r_reg.st)
                BUS_IDLE: begin
                end
                BUS_ADDR, BUS_RX: begin
                    if (rise) begin
                        r_next.shift  = {r_reg.shift[6:0], sda};
                        r_next.bitCnt = 4'(r_reg.bitCnt + 4'h1);
                    end else if (fall && r_reg.bitCnt == BITS_PER_BYTE) begin
                        r_next.bitCnt = 4'h0;
                        if (r_reg.st == BUS_RX) begin
                            r_next.rxValid = 1'b1;
                            r_next.drive   = 1'b1;
                            r_next.isAddr  = 1'b0;
                            r_next.st      = BUS_ACK;
                        end else if (r_reg.shift[7:1] == bus.slaveAddr) begin
                            r_next.drive  = 1'b1;
                            r_next.rw     = r_reg.shift[0];
                            r_next.isAddr = 1'b1;
                            r_next.st     = BUS_ACK;
                        end else begin
                            r_next.st = BUS_IDLE;
                        end
                    end
                end
                BUS_ACK: begin
                    if (fall && r_reg.isAddr && r_reg.rw) begin
                        r_next.shift  = bus.txData;
                        r_next.drive  = ~bus.txData[7];
                        r_next.txTake = 1'b1;
                        r_next.st     = BUS_TX;
                    end else if (fall) begin
                        r_next.drive = 1'b0;
                        r_next.st    = BUS_RX;
                    end
                end
                BUS_TX: begin
                    if (rise) begin
                        r_next.bitCnt = 4'(r_reg.bitCnt + 4'h1);
                    end else if (fall && r_reg.bitCnt == BITS_PER_BYTE) begin
                        r_next.drive  = 1'b0;
                        r_next.bitCnt = 4'h0;
                        r_next.st     = BUS_TXACK;
                    end else if (fall) begin
                        r_next.shift = {r_reg.shift[6:0], 1'b0};
                        r_next.drive = ~r_reg.shift[6];
                    end
                end
                BUS_TXACK: begin
                    if (rise) begin
                        r_next.hostAck = ~sda;
                    end else if (fall && r_reg.hostAck) begin
                        r_next.shift  = bus.txData;
                        r_next.drive  = ~bus.txData[7];
                        r_next.txTake = 1'b1;
                        r_next.st     = BUS_TX;
                    end else if (fall) begin
                        r_next.st = BUS_IDLE;
                    end
                end
                default: r_next.st = BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= ENG_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign sdaOut         = 1'b0;
    assign sdaOe_n        = ~r_reg.drive;
    assign bus.frameStart = r_reg.frameStart;
    assign bus.frameStop  = r_reg.frameStop;
    assign bus.rxValid    = r_reg.rxValid;
    assign bus.rxData     = r_reg.shift;
    assign bus.txTake     = r_reg.txTake;
endmodule

// ---- core/fanout_cfg_regs.sv ----
// configuration and identification register bank of the clock fanout buffer
//
// Functional notes
// R1: cleared gate forces output pair low/low
// R2: byte 1 bit 5 gates output 4
// R3: byte 1 bits 1:0 select swing
// R4: byte 2 edge speed selects outputs 0-3
// R5: byte 3 bit 0 edge speed output 4
// R6: byte 4 always reads all ones
// R7: byte 5 holds revision and maker code
// R8: byte 6 holds class and part id
// R9: byte 7 sets block read length
// R10: byte 1 reserved bits read fixed values
// R11: block write: index, count, then data
// R12: block read: count first, then bytes
// R13: bus address latched from select pin
// R14: writes to fixed bits are ignored
`timescale 1ns/10ps
module fanout_cfg_regs
    import fanout_cfg_pkg::*;
#(
    parameter int         ADDR_SEL_W = 2,     // width of address select strap
    parameter logic [6:0] BASE_ADDR  = 7'h50, // address for select code zero
    parameter logic [3:0] REV_CODE   = 4'h2,  // arbitrary value
    parameter logic [3:0] MAKER_CODE = 4'h7,  // arbitrary value
    parameter logic [1:0] CLASS_CODE = 2'h2,  // arbitrary value
    parameter logic [5:0] PART_ID    = 6'h2a  // arbitrary value
) (
    input  wire logic                  clk,       // 20 MHz clock
    input  wire logic                  rst_n,     // synchronous reset
    input  wire logic                  scl,       // serial clock pin
    input  wire logic                  sdaIn,     // serial data pin level
    output logic                       sdaOut,    // serial data drive value
    output logic                       sdaOe_n,   // serial data enable, low drives
    input  wire logic [ADDR_SEL_W-1:0] addrSel,   // address select pin
    input  wire logic                  out4Pin_n, // output 4 enable pin
    output logic                       out4Run,   // output 4 running
    output logic [1:0]                 swingSel,  // output amplitude code
    output logic [4:0]                 edgeSpeed  // per-output fast edge select
);
    if (ADDR_SEL_W < 1 || ADDR_SEL_W > 3) begin : g_chk
        $error("address select width not supported");
    end

    typedef struct packed {
        logic                  gate4;
        logic [1:0]            swing;
        logic [4:0]            edgeSel;
        logic [LEN_W-1:0]      lenCnt;
        logic [7:0]            index;
        logic [7:0]            remain;
        wr_phase_e             wrPhase;
        logic                  readFirst;
        logic [6:0]            addrLatch;
        logic                  addrDone;
        logic [1:0]            capCnt;
        logic [ADDR_SEL_W-1:0] sel0;
        logic [ADDR_SEL_W-1:0] sel1;
        logic [1:0]            pinSync;
        logic                  run4;
    } regs_s;

    localparam regs_s REGS_RST = '{gate4: GATE4_RST, swing: SWING_RST, edgeSel: EDGE_RST,
                                   lenCnt: LEN_RST, index: 8'h00, remain: 8'h00, wrPhase: WR_INDEX,
                                   readFirst: 1'b1, addrLatch: 7'h00, addrDone: 1'b0, capCnt: 2'h0,
                                   sel0: '0, sel1: '0, pinSync: 2'h0, run4: 1'b0};

    function automatic logic [7:0] regRead(input regs_s s, input logic [7:0] idx);
        logic [7:0] v;
        v = UNMAPPED_VALUE;
        case (idx)
            IDX_GATE_SWING: begin
                v                   = GATE_SWING_FIXED; // [R10]
                v[GATE4_BIT]        = s.gate4;
                v[SWING_LSB+:2]     = s.swing;
            end
            IDX_EDGE_LO: begin
                v            = EDGE_LO_FIXED;
                v[EDGE0_BIT] = s.edgeSel[0];
                v[EDGE1_BIT] = s.edgeSel[1];
                v[EDGE2_BIT] = s.edgeSel[2];
                v[EDGE3_BIT] = s.edgeSel[3];
            end
            IDX_EDGE_HI: begin
                v            = EDGE_HI_FIXED;
                v[EDGE4_BIT] = s.edgeSel[4];
            end
            IDX_RSVD: v = RSVD_VALUE; // [R6]
            IDX_REV:  v = {REV_CODE, MAKER_CODE}; // [R7]
            IDX_PART: v = {CLASS_CODE, PART_ID}; // [R8]
            IDX_LEN: begin
                v            = LEN_FIXED;
                v[LEN_W-1:0] = s.lenCnt; // [R9]
            end
            default: v = UNMAPPED_VALUE;
        endcase
        return v;
    endfunction

    regs_s        r_reg;
    regs_s        r_next;
    smbus_byte_if bus ();

    smbus_byte_engine u_engine (
        .clk     (clk),
        .rst_n   (rst_n),
        .sclIn   (scl),
        .sdaIn   (sdaIn),
        .sdaOut  (sdaOut),
        .sdaOe_n (sdaOe_n),
        .bus     (bus)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_next         = r_reg;
        r_next.sel0    = addrSel;
        r_next.sel1    = r_reg.sel0;
        r_next.pinSync = {r_reg.pinSync[0], out4Pin_n};
        r_next.run4    = r_reg.gate4 & ~r_reg.pinSync[1]; // [R1]
        if (!r_reg.addrDone) begin
            r_next.capCnt = 2'(r_reg.capCnt + 2'h1);
            if (r_reg.capCnt == STRAP_SETTLE) begin
                r_next.addrLatch = 7'(BASE_ADDR + 7'(r_reg.sel1)); // [R13]
                r_next.addrDone  = 1'b1;
            end
        end
        if (bus.frameStart) begin
            r_next.wrPhase   = WR_INDEX;
            r_next.readFirst = 1'b1;
        end
        if (bus.rxValid) begin
            unique case (r_reg.wrPhase)
                WR_INDEX: begin
                    r_next.index   = bus.rxData; // [R11]
                    r_next.wrPhase = WR_COUNT;
                end
                WR_COUNT: begin
                    r_next.remain  = bus.rxData; // [R11]
                    r_next.wrPhase = WR_DATA;
                end
                WR_DATA: begin
                    if (r_reg.remain != 8'h00) begin
                        r_next.remain = 8'(r_reg.remain - 8'h01);
                        r_next.index  = 8'(r_reg.index + 8'h01); // [R11]
                        case (r_reg.index) // [R14]
                            IDX_GATE_SWING: begin
                                r_next.gate4 = bus.rxData[GATE4_BIT]; // [R2]
                                r_next.swing = bus.rxData[SWING_LSB+:2]; // [R3]
                            end
                            IDX_EDGE_LO: begin
                                r_next.edgeSel[0] = bus.rxData[EDGE0_BIT]; // [R4]
                                r_next.edgeSel[1] = bus.rxData[EDGE1_BIT];
                                r_next.edgeSel[2] = bus.rxData[EDGE2_BIT];
                                r_next.edgeSel[3] = bus.rxData[EDGE3_BIT];
                            end
                            IDX_EDGE_HI: r_next.edgeSel[4] = bus.rxData[EDGE4_BIT]; // [R5]
                            IDX_LEN:     r_next.lenCnt = bus.rxData[LEN_W-1:0]; // [R9]
                            default: begin
                            end
                        endcase
                    end
                end
            endcase
        end
        if (bus.txTake && r_reg.readFirst) begin
            r_next.readFirst = 1'b0; // [R12]
        end else if (bus.txTake) begin
            r_next.index = 8'(r_reg.index + 8'h01); // [R12]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= REGS_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // count byte leads every read reply, register bytes follow
    assign bus.txData    = r_reg.readFirst ? {{(8-LEN_W){1'b0}}, r_reg.lenCnt} : regRead(r_reg, r_reg.index);
    assign bus.slaveAddr = r_reg.addrLatch;
    assign out4Run       = r_reg.run4;
    assign swingSel      = r_reg.swing;
    assign edgeSpeed     = r_reg.edgeSel;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    logic dataWrite;
    assign dataWrite = bus.rxValid && r_reg.wrPhase == WR_DATA && r_reg.remain != 8'h00;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_GATE_LOW: assert property (!r_reg.gate4 |=> !out4Run) // [R1]
        else $error("cleared gate did not hold output 4 low");
    AST_GATE_WRITE: assert property ((dataWrite && r_reg.index == IDX_GATE_SWING) // [R2]
        |=> r_reg.gate4 == $past(bus.rxData[GATE4_BIT]) ##1 out4Run == $past(r_reg.gate4 && !r_reg.pinSync[1]))
        else $error("gate write or output follow wrong");
    AST_SWING_WRITE: assert property ((dataWrite && r_reg.index == IDX_GATE_SWING) // [R3]
        |=> swingSel == $past(bus.rxData[SWING_LSB+:2]))
        else $error("swing field not written");
    AST_EDGE_LO: assert property ((dataWrite && r_reg.index == IDX_EDGE_LO) // [R4]
        |=> edgeSpeed[3] == $past(bus.rxData[EDGE3_BIT]) && edgeSpeed[0] == $past(bus.rxData[EDGE0_BIT]))
        else $error("edge speed outputs 0-3 not written");
    AST_EDGE_HI: assert property ((dataWrite && r_reg.index == IDX_EDGE_HI) // [R5]
        |=> edgeSpeed[4] == $past(bus.rxData[EDGE4_BIT]) && $stable(edgeSpeed[3:0]))
        else $error("edge speed output 4 wrong");
    AST_RSVD_ONES: assert property ((!r_reg.readFirst && r_reg.index == IDX_RSVD) |-> bus.txData == RSVD_VALUE) // [R6]
        else $error("reserved byte not all ones");
    AST_ID_CODES: assert property ((!r_reg.readFirst && r_reg.index == IDX_REV) // [R7]
        |-> bus.txData == {REV_CODE, MAKER_CODE})
        else $error("revision byte wrong");
    AST_PART_CODE: assert property ((!r_reg.readFirst && r_reg.index == IDX_PART) // [R8]
        |-> bus.txData == {CLASS_CODE, PART_ID})
        else $error("part byte wrong");
    AST_COUNT_FIRST: assert property (bus.frameStart |=> r_reg.readFirst && bus.txData[LEN_W-1:0] == r_reg.lenCnt) // [R12]
        else $error("read reply does not open with count");
    AST_INDEX_STEP: assert property ((bus.txTake && !r_reg.readFirst) |=> r_reg.index == 8'($past(r_reg.index) + 8'h01)) // [R12]
        else $error("read index did not advance");
    AST_INDEX_LOAD: assert property ((bus.rxValid && r_reg.wrPhase == WR_INDEX) // [R11]
        |=> r_reg.index == $past(bus.rxData) && r_reg.wrPhase == WR_COUNT)
        else $error("start index not captured");
    AST_RSVD_B1: assert property ((!r_reg.readFirst && r_reg.index == IDX_GATE_SWING) // [R10]
        |-> (bus.txData & 8'hdc) == GATE_SWING_FIXED)
        else $error("byte 1 reserved bits wrong");
    AST_RO_IGNORED: assert property ((dataWrite && r_reg.index == IDX_REV) |=> $stable(r_reg[$bits(regs_s)-1 -: 13])) // [R14]
        else $error("write to read-only byte changed state");
    AST_ADDR_HOLD: assert property (r_reg.addrDone |=> $stable(r_reg.addrLatch)) // [R13]
        else $error("latched address changed");

    COV_WRITE_GATE: cover property (dataWrite && r_reg.index == IDX_GATE_SWING);
    COV_READ_COUNT: cover property (bus.txTake && r_reg.readFirst);
    COV_READ_BYTE:  cover property (bus.txTake && !r_reg.readFirst ##[1:1000] bus.txTake);
    COV_PIN_OFF:    cover property (r_reg.gate4 && r_reg.pinSync[1] ##1 !out4Run);
    COV_WRITE_END:  cover property (dataWrite ##[1:1000] bus.frameStop);
endmodule

// ---- dv/smbus_host_model.sv ----
// serial host model issuing indexed block transfers
`timescale 1ns/10ps
module smbus_host_model (
    input  wire logic clk,     // system clock
    input  wire logic sdaWire, // resolved data line
    output logic      scl,     // serial clock drive
    output logic      sdaHost  // data drive, 0 pulls low
);
    initial begin
        scl = 1'b1;
        sdaHost = 1'b1;
    end
    // each bus phase spans 8 clocks, well above the synchroniser needs
    task automatic phase();
        repeat (8) @(posedge clk);
    endtask
    task automatic putBit(input logic b);
        sdaHost <= b;
        phase();
        scl <= 1'b1;
        phase();
        scl <= 1'b0;
    endtask
    task automatic getBit(output logic b);
        sdaHost <= 1'b1;
        phase();
        scl <= 1'b1;
        phase();
        b = sdaWire;
        scl <= 1'b0;
    endtask
    task automatic start();
        sdaHost <= 1'b1;
        phase();
        scl <= 1'b1;
        phase();
        sdaHost <= 1'b0;
        phase();
        scl <= 1'b0;
    endtask
    task automatic stop();
        sdaHost <= 1'b0;
        phase();
        scl <= 1'b1;
        phase();
        sdaHost <= 1'b1;
        phase();
    endtask
    task automatic wrByte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) putBit(d[i]);
        getBit(a);
        ack = ~a;
    endtask
    task automatic rdByte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) getBit(d[i]);
        putBit(last);
    endtask
endmodule

// ---- dv/fanout_cfg_regs_tb_top.sv ----
// self-checking bench of the configuration register bank
`timescale 1ns/10ps
module fanout_cfg_regs_tb_top;
    import fanout_cfg_pkg::*;
    localparam logic [3:0] REV_T   = 4'h9;  // arbitrary value
    localparam logic [3:0] MAKER_T = 4'h6;  // arbitrary value
    localparam logic [1:0] CLASS_T = 2'h1;  // arbitrary value
    localparam logic [5:0] PART_T  = 6'h33; // arbitrary value
    localparam logic [6:0] DEV     = 7'h51;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [1:0] addrSel = 2'h1;
    logic       out4Pin_n = 1'b0;
    logic       scl, sdaHost, sdaOut, sdaOe_n, out4Run, sdaWire;
    logic [1:0] swingSel;
    logic [4:0] edgeSpeed, spd, len;
    logic       gate4;
    logic [1:0] swing;
    int         bad_count = 0;
    int         checks_done = 0;
    assign sdaWire = sdaHost & (sdaOe_n | sdaOut);
    always #25 clk = ~clk;
    smbus_host_model i_smbus_host_model (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaHost(sdaHost));
    fanout_cfg_regs #(.REV_CODE(REV_T), .MAKER_CODE(MAKER_T), .CLASS_CODE(CLASS_T), .PART_ID(PART_T))
    i_fanout_cfg_regs (.clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOe_n(sdaOe_n), .addrSel(addrSel), .out4Pin_n(out4Pin_n), .out4Run(out4Run),
        .swingSel(swingSel), .edgeSpeed(edgeSpeed));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] expByte(input logic [7:0] idx);
        case (idx)
            8'h01: return 8'h4c | {2'h0, gate4, 3'h0, swing};
            8'h02: return 8'h95 | {1'b0, spd[3], spd[2], 1'b0, spd[1], 1'b0, spd[0], 1'b0};
            8'h03: return 8'h46 | {7'h0, spd[4]};
            8'h04: return 8'hff;
            8'h05: return {REV_T, MAKER_T};
            8'h06: return {CLASS_T, PART_T};
            8'h07: return {3'h0, len};
            default: return 8'h00;
        endcase
    endfunction
    task automatic upd(input logic [7:0] idx, input logic [7:0] d);
        case (idx)
            8'h01: {gate4, swing} = {d[5], d[1:0]};
            8'h02: spd[3:0] = {d[6], d[5], d[3], d[1]};
            8'h03: spd[4] = d[0];
            8'h07: len = d[4:0];
            default: ;
        endcase
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic blkWrite(input logic [6:0] a, input logic [7:0] idx, input int x, input int extra,
                            input logic rnd, input logic [7:0] fill);
        logic       ak;
        logic [7:0] d;
        i_smbus_host_model.start();
        i_smbus_host_model.wrByte({a, 1'b0}, ak);
        chk("address ack", {7'h0, ak}, {7'h0, a == DEV});
        if (ak) begin
            i_smbus_host_model.wrByte(idx, ak);
            chk("index ack", {7'h0, ak}, 8'h01);
            i_smbus_host_model.wrByte(x[7:0], ak);
            chk("count ack", {7'h0, ak}, 8'h01);
            for (int k = 0; k < x + extra; k++) begin
                d = rnd ? 8'($urandom) : fill;
                i_smbus_host_model.wrByte(d, ak);
                chk("data ack", {7'h0, ak}, 8'h01);
                if (k < x) upd(idx + 8'(k), d);
            end
        end
        i_smbus_host_model.stop();
    endtask
    task automatic blkRead(input logic [7:0] idx, input int n);
        logic       ak;
        logic [7:0] d;
        i_smbus_host_model.start();
        i_smbus_host_model.wrByte({DEV, 1'b0}, ak);
        i_smbus_host_model.wrByte(idx, ak);
        i_smbus_host_model.start();
        i_smbus_host_model.wrByte({DEV, 1'b1}, ak);
        chk("read address ack", {7'h0, ak}, 8'h01);
        i_smbus_host_model.rdByte(d, 1'b0);
        chk("count byte", d, {3'h0, len});
        for (int k = 0; k < n; k++) begin
            i_smbus_host_model.rdByte(d, k == n - 1);
            chk("register byte", d, expByte(idx + 8'(k)));
        end
        i_smbus_host_model.stop();
    endtask
    task automatic chkPorts();
        repeat (6) @(posedge clk);
        chk("out4Run", {7'h0, out4Run}, {7'h0, gate4 & ~out4Pin_n});
        chk("swingSel", {6'h0, swingSel}, {6'h0, swing});
        chk("edgeSpeed", {3'h0, edgeSpeed}, {3'h0, spd});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h670146c1));
        {gate4, swing, spd, len} = {1'b1, 2'b10, 5'h1f, 5'h08};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        addrSel <= 2'h2;
        chkPorts();
        blkRead(8'h00, 10);
        blkWrite(7'h52, 8'h01, 1, 0, 1'b0, 8'h00);
        blkWrite(DEV, 8'h01, 7, 1, 1'b0, 8'h00);
        chkPorts();
        blkRead(8'h00, 10);
        blkWrite(DEV, 8'h01, 7, 0, 1'b0, 8'hff);
        chkPorts();
        blkRead(8'h01, 8);
        for (int it = 0; it < 10; it++) begin
            @(posedge clk);
            out4Pin_n <= 1'($urandom_range(0, 1));
            blkWrite(DEV, 8'($urandom_range(0, 8)), $urandom_range(1, 4), $urandom_range(0, 1), 1'b1, 8'h00);
            chkPorts();
            blkRead(8'($urandom_range(0, 3)), $urandom_range(1, 9));
        end
        end_of_test();
    end
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule
